// [logic/adcc_control.sv]
// Conversion and calibration control of a self-calibrating SAR converter
`default_nettype none
module adcc_control
   import adcc_pkg::*;
#(
   parameter int RESET_CAL_LEN = RESET_CAL_CYCLES,
   parameter int RES_BITS = RESULT_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hold_n,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic read_address_select,
   input wire logic cal_request,
   input wire logic interleave_cal_request_n,
   input wire logic loopback,
   input wire logic sar_compare,
   output logic [BUS_BITS-1:0] data_out,
   output logic data_oe,
   output logic eoc,
   output logic holding,
   output logic cal_busy,
   output logic [RES_BITS-1:0] dac_code,
   output logic [TRIM_BITS-1:0] cal_trim
);
   localparam int CONV_CYCLES = RES_BITS * CYCLES_PER_BIT;

   // Counter is 16 bits wide, so longer calibrations cannot be timed
   if (RESET_CAL_LEN < 1 || RESET_CAL_LEN > 65535 || RES_BITS < 2 || RES_BITS > BUS_BITS) begin : g_bad_param
      $error("adcc_control: unsupported parameter value");
   end

   adcc_state_type state, next_state;
   logic [15:0] cnt, next_cnt;
   logic [6:0] pcnt, next_pcnt;
   logic [RES_BITS-1:0] mask, next_mask, result, next_result, next_dac_code, decided;
   logic [TRIM_BITS-1:0] next_cal_trim;
   logic burst_req, next_burst_req, ilv_en, next_ilv_en;
   logic hold_prev, cs_prev;
   logic next_eoc, next_holding, next_cal_busy, next_data_oe;
   logic [BUS_BITS-1:0] next_data_out;
   logic soft_reset, int_reset, hold_fall, cs_rise, burst_stop, data_read, start_conv, conv_end;

   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = v + 16'h0001;
   endfunction : inc16

   assign soft_reset = !chip_select_n && !hold_n && !read_address_select;
   assign int_reset = rst || soft_reset;
   assign hold_fall = hold_prev && !hold_n;
   assign cs_rise = !cs_prev && chip_select_n;
   assign burst_stop = !chip_select_n && !cal_request && hold_n;
   assign data_read = !chip_select_n && !read_n && read_address_select;
   // Loopback restarts itself once a full period has gone by
   assign start_conv = hold_fall || (loopback && pcnt >= 7'(LOOP_PERIOD_CYCLES - 1));
   assign conv_end = (state == S_CONVERT) && (cnt == 16'(CONV_CYCLES - 1));
   assign decided = sar_compare ? dac_code : (dac_code & ~mask);

   always_comb begin
      next_state = state;
      next_cnt = inc16(cnt);
      next_pcnt = (pcnt == 7'h7F) ? pcnt : pcnt + 7'h01;
      next_mask = mask;
      next_result = result;
      next_dac_code = dac_code;
      next_cal_trim = cal_trim;
      next_burst_req = burst_req;
      next_ilv_en = ilv_en;
      next_eoc = eoc;
      next_holding = holding;
      next_cal_busy = 1'b0;
      // CAL and interleave are sampled as CS rises; CAL low with CS low and hold high also clears the burst request
      if (cs_rise) begin
         next_burst_req = cal_request;
         next_ilv_en = !interleave_cal_request_n;
      end
      if (burst_stop) begin
         next_burst_req = 1'b0;
      end
      if (data_read) begin
         next_eoc = 1'b1;
      end
      unique case (state)
         S_CAL_RESET: begin
            next_cal_busy = 1'b1;
            next_cal_trim = cal_trim + 15'h0001;
            if (cnt == 16'(RESET_CAL_LEN - 1)) begin
               next_state = S_IDLE;
               next_eoc = 1'b0;
               next_cal_busy = 1'b0;
            end
         end
         S_IDLE: begin
            next_holding = 1'b0;
            if (burst_req) begin
               next_state = S_BURST;
               next_cal_busy = 1'b1;
            end else if (start_conv) begin
               next_state = S_CONVERT;
               next_cnt = 16'h0000;
               next_pcnt = 7'h00;
               next_holding = 1'b1;
               next_eoc = 1'b1;
               next_mask = {1'b1, {(RES_BITS-1){1'b0}}};
               next_dac_code = {1'b1, {(RES_BITS-1){1'b0}}};
            end
         end
         S_CONVERT: begin
            // One bit is decided per bit period, MSB first
            if (cnt[1:0] == 2'(CYCLES_PER_BIT - 1)) begin
               next_mask = mask >> 1;
               next_dac_code = decided | (mask >> 1);
            end
            if (conv_end) begin
               next_result = decided;
               next_holding = 1'b0;
               next_cnt = 16'h0000;
               if (ilv_en) begin
                  next_state = S_ILV_CAL;
                  next_cal_busy = 1'b1;
               end else begin
                  next_eoc = 1'b0;
                  // A burst request seen mid conversion starts only now
                  next_state = burst_req ? S_BURST : S_IDLE;
                  next_cal_busy = burst_req;
               end
            end
         end
         S_ILV_CAL: begin
            next_cal_busy = 1'b1;
            if (cnt == 16'(ILV_EXTRA_CYCLES - 1)) begin
               next_cal_trim = cal_trim + 15'h0001;
               next_eoc = 1'b0;
               next_cal_busy = burst_req;
               next_state = burst_req ? S_BURST : S_IDLE;
            end
         end
         S_BURST: begin
            // Trim keeps its value so a later burst picks up from here
            next_cal_trim = cal_trim + 15'h0001;
            next_cal_busy = 1'b1;
            if (!next_burst_req) begin
               next_state = S_IDLE;
               next_cal_busy = 1'b0;
            end
         end
      endcase
   end

   // Bus answer; address select also matters in reset decode and in the data read that sets eoc
   always_comb begin
      next_data_oe = !chip_select_n && !read_n;
      next_data_out = '0;
      if (next_data_oe) begin
         if (read_address_select) begin
            next_data_out = BUS_BITS'(result);
         end else begin
            next_data_out[ST_EOC_BIT] = eoc;
            next_data_out[ST_CONV_BIT] = (state == S_CONVERT);
            next_data_out[ST_CAL_BIT] = cal_busy;
            next_data_out[ST_BURST_BIT] = burst_req;
            next_data_out[ST_ILV_BIT] = ilv_en;
            next_data_out[ST_LOOP_BIT] = loopback;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (int_reset) begin
         state <= S_CAL_RESET;
         cnt <= 16'h0000;
         pcnt <= 7'h00;
         mask <= '0;
         result <= '0;
         dac_code <= '0;
         cal_trim <= TRIM_RESET;
         burst_req <= 1'b0;
         ilv_en <= 1'b0;
         hold_prev <= 1'b1;
         cs_prev <= 1'b1;
         eoc <= EOC_RESET;
         holding <= 1'b0;
         cal_busy <= 1'b1;
         data_oe <= 1'b0;
         data_out <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         pcnt <= next_pcnt;
         mask <= next_mask;
         result <= next_result;
         dac_code <= next_dac_code;
         cal_trim <= next_cal_trim;
         burst_req <= next_burst_req;
         ilv_en <= next_ilv_en;
         hold_prev <= hold_n;
         cs_prev <= chip_select_n;
         eoc <= next_eoc;
         holding <= next_holding;
         cal_busy <= next_cal_busy;
         data_oe <= next_data_oe;
         data_out <= next_data_out;
      end
   end

   property p_tristate;
      @(posedge clk) disable iff (rst) (chip_select_n || read_n) |=> !data_oe && data_out == '0;
   endproperty
   a_tristate: assert property (p_tristate) else $error("bus driven while deselected");

   property p_read_data;
      // Completion on the same edge keeps eoc low
      @(posedge clk) disable iff (rst)
         (data_read && !conv_end && !(state == S_ILV_CAL && cnt == 16'(ILV_EXTRA_CYCLES - 1)) &&
         !(state == S_CAL_RESET && cnt == 16'(RESET_CAL_LEN - 1))) |=>
         data_oe && data_out == BUS_BITS'($past(result)) && eoc;
   endproperty
   a_read_data: assert property (p_read_data) else $error("data read wrong");

   property p_read_status;
      @(posedge clk) disable iff (rst)
         (!chip_select_n && !read_n && !read_address_select && hold_n) |=> data_oe && data_out[15:8] == 8'h00;
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read wrong");

   property p_hold_start;
      @(posedge clk) disable iff (rst)
         (state == S_IDLE && hold_fall && !burst_req && !soft_reset) |=> state == S_CONVERT && holding && eoc;
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("hold edge did not start conversion");

   property p_soft_reset;
      @(posedge clk) disable iff (rst) soft_reset |=> state == S_CAL_RESET && cnt == 16'h0000 && eoc;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("software reset missed");

   property p_cal_eoc;
      @(posedge clk) disable iff (rst)
         (state == S_CAL_RESET && cnt == 16'(RESET_CAL_LEN - 1) && !soft_reset) |=> !eoc && state == S_IDLE;
   endproperty
   a_cal_eoc: assert property (p_cal_eoc) else $error("EOC did not fall after reset calibration");

   property p_loop;
      @(posedge clk) disable iff (rst)
         (state == S_CONVERT && cnt == 16'h0000 && loopback && !ilv_en && !burst_req) ##1
         (loopback && !burst_req && !soft_reset && !hold_fall)[*8] |->
         ##56 ((state == S_CONVERT && cnt == 16'h0000) || soft_reset || burst_req || !loopback);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback period wrong");

   property p_ilv;
      @(posedge clk) disable iff (rst)
         (conv_end && ilv_en && !soft_reset) |=> state == S_ILV_CAL ##19 (eoc && state == S_ILV_CAL);
   endproperty
   a_ilv: assert property (p_ilv) else $error("interleave step length wrong");

   property p_burst_stop;
      @(posedge clk) disable iff (rst) (state == S_BURST && burst_stop && !soft_reset) |=> state == S_IDLE;
   endproperty
   a_burst_stop: assert property (p_burst_stop) else $error("burst calibration not stopped");

   property p_trim;
      @(posedge clk) disable iff (rst) (state == S_BURST && !soft_reset) |=> cal_trim == 15'($past(cal_trim) + 1);
   endproperty
   a_trim: assert property (p_trim) else $error("trim did not advance");

   property p_wait_conv;
      @(posedge clk) disable iff (rst) (conv_end && burst_req && !ilv_en && !soft_reset) |=> state == S_BURST && !eoc;
   endproperty
   a_wait_conv: assert property (p_wait_conv) else $error("calibration did not follow conversion");
endmodule : adcc_control
`default_nettype wire

// [logic/adcc_pkg.sv]
// Constants shared by the converter control logic
`default_nettype none
package adcc_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_PULSE_NS = 100;
   localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CAL_CYCLES = 58280;
   localparam int LOOP_PERIOD_CYCLES = 64;
   localparam int ILV_EXTRA_CYCLES = 20;
   localparam int CYCLES_PER_BIT = 4;
   localparam int RESULT_BITS = 12;
   localparam int BUS_BITS = 16;
   localparam int TRIM_BITS = 15;
   // Status byte field positions
   localparam int ST_EOC_BIT = 0;
   localparam int ST_CONV_BIT = 1;
   localparam int ST_CAL_BIT = 2;
   localparam int ST_BURST_BIT = 3;
   localparam int ST_ILV_BIT = 4;
   localparam int ST_LOOP_BIT = 5;
   // Reset values
   localparam logic [TRIM_BITS-1:0] TRIM_RESET = 15'h0000;
   localparam logic EOC_RESET = 1'b1;
   typedef enum logic [2:0] {S_CAL_RESET, S_IDLE, S_CONVERT, S_ILV_CAL, S_BURST} adcc_state_type;
endpackage : adcc_pkg
`default_nettype wire

// [verification/adcc_cmp_model.sv]
// Comparator model facing the trial code
`default_nettype none
module adcc_cmp_model
   import adcc_pkg::*;
(
   input wire logic [RESULT_BITS-1:0] dac_code,
   input wire logic [RESULT_BITS-1:0] vin,
   output logic sar_compare
);
   timeunit 1ns;
   timeprecision 1ns;
   // Ideal, no offset, so result equals vin
   assign sar_compare = (vin >= dac_code);
endmodule : adcc_cmp_model
`default_nettype wire

// [verification/adc_conversion_calibration_control_bench.sv]
// Self-checking bench for the converter control
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module adc_conversion_calibration_control_bench;
   import adcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CAL_LEN = 50;
   localparam int CONV = RESULT_BITS * CYCLES_PER_BIT;
   logic clk = 0, rst = 1, hold_n = 1, cs_n = 1, read_n = 1, addr = 1, cal = 0, ilv_n = 1, lb = 0;
   logic cmp, oe, eoc, holding, busy;
   logic [BUS_BITS-1:0] dout, v;
   logic [RESULT_BITS-1:0] dac, vin = 12'h000;
   logic [TRIM_BITS-1:0] trim, seen;
   int error_cnt = 0, tests_run = 0, n, i;
   always #50 clk = ~clk;
   adcc_control #(.RESET_CAL_LEN(CAL_LEN), .RES_BITS(RESULT_BITS)) dut (.clk(clk), .rst(rst), .hold_n(hold_n),
      .chip_select_n(cs_n), .read_n(read_n), .read_address_select(addr), .cal_request(cal),
      .interleave_cal_request_n(ilv_n), .loopback(lb), .sar_compare(cmp), .data_out(dout), .data_oe(oe),
      .eoc(eoc), .holding(holding), .cal_busy(busy), .dac_code(dac), .cal_trim(trim));
   adcc_cmp_model cmp_model (.dac_code(dac), .vin(vin), .sar_compare(cmp));
   task automatic end_sim;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Bounded so a stuck eoc cannot hang the run
   task automatic wait_eoc(output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
         if (c == 2) hold_n = 1;
      end while (eoc !== 1'b0 && c < 2000);
   endtask : wait_eoc
   task automatic rd(input logic a, output logic [BUS_BITS-1:0] d);
      cs_n = 0;
      read_n = 0;
      addr = a;
      @(negedge clk);
      `CHK(oe, 1'b1)
      d = dout;
      cs_n = 1;
      read_n = 1;
      addr = 1'($urandom);
      @(negedge clk);
      `CHK(oe, 1'b0)
      `CHK(dout, 16'h0000)
   endtask : rd
   task automatic conv(input logic [RESULT_BITS-1:0] x, input int len);
      vin = x;
      hold_n = 0;
      @(posedge clk);
      wait_eoc(n);
      // Last count falls on the negedge after eoc has already dropped
      `CHK(n - 1, len)
      rd(1'b1, v);
      `CHK(v, {4'h0, x})
   endtask : conv
   task automatic recal;
      wait_eoc(n);
      `CHK(n >= CAL_LEN && n <= CAL_LEN + 3, 1'b1)
      `CHK(busy, 1'b0)
      rd(1'b1, v);
   endtask : recal
   initial begin
      i = $urandom(75804);
      repeat (10) @(posedge clk);
      @(negedge clk);
      `CHK(eoc, 1'b1)
      `CHK(trim, TRIM_RESET)
      rst = 0;
      recal();
      read_n = 0;
      @(negedge clk);
      `CHK(oe, 1'b0)
      read_n = 1;
      conv(12'h000, CONV);
      conv(12'hFFF, CONV);
      for (i = 0; i < 6; i++) conv(12'($urandom), CONV);
      $display("test convert done");
      ilv_n = 0;
      rd(1'b0, v);
      `CHK(v[ST_CONV_BIT], 1'b0)
      conv(12'($urandom), CONV + ILV_EXTRA_CYCLES);
      rd(1'b0, v);
      `CHK(v[ST_ILV_BIT], 1'b1)
      ilv_n = 1;
      rd(1'b0, v);
      conv(12'($urandom), CONV);
      $display("test interleave done");
      // Burst only here, hosts are steered away from it
      vin = 12'h5A5;
      // Address high, else CS low with hold low is a software reset
      addr = 1;
      hold_n = 0;
      @(posedge clk);
      @(negedge clk);
      cal = 1;
      cs_n = 0;
      @(negedge clk);
      cs_n = 1;
      wait_eoc(n);
      `CHK(n + 1, CONV)
      repeat (3) @(negedge clk);
      `CHK(busy, 1'b1)
      seen = trim;
      hold_n = 0;
      repeat (3) @(negedge clk);
      `CHK(holding, 1'b0)
      `CHK(trim !== seen, 1'b1)
      hold_n = 1;
      cal = 0;
      cs_n = 0;
      repeat (2) @(negedge clk);
      `CHK(busy, 1'b0)
      cs_n = 1;
      @(negedge clk);
      rd(1'b1, v);
      `CHK(v, 16'h05A5)
      $display("test burst done");
      cs_n = 0;
      hold_n = 0;
      addr = 0;
      @(negedge clk);
      cs_n = 1;
      hold_n = 1;
      addr = 1;
      `CHK(busy, 1'b1)
      `CHK(eoc, 1'b1)
      recal();
      $display("test soft reset done");
      lb = 1;
      vin = 12'($urandom);
      i = 0;
      while (holding !== 1'b1 && i < 200) begin @(negedge clk); i++; end
      n = 0;
      while (holding !== 1'b0 && n < 200) begin @(negedge clk); n++; end
      while (holding !== 1'b1 && n < 200) begin @(negedge clk); n++; end
      `CHK(n, LOOP_PERIOD_CYCLES)
      lb = 0;
      $display("test loopback done");
      rst = 1;
      repeat (RESET_PULSE_CYCLES) @(negedge clk);
      `CHK(busy, 1'b1)
      `CHK(oe, 1'b0)
      rst = 0;
      recal();
      $display("test mid reset done");
      end_sim();
   end
   initial begin
      #(CLK_PERIOD_NS * 5000);
      error_cnt++;
      end_sim();
   end
endmodule : adc_conversion_calibration_control_bench
`default_nettype wire
